// File: shared/ext_mem_map.vh
// Register map, field positions, reset values and timing constants of the external memory sequencer
`ifndef EXT_MEM_MAP_VH
`define EXT_MEM_MAP_VH

`define OFS_TIMING 8'h00
`define OFS_CONFIG 8'h04
`define OFS_BANK 8'h08
`define OFS_STATUS 8'h0c

`define RST_TIMING 8'hff
`define RST_CONFIG 8'h03
`define RST_BANK 8'h00

`define TC_SETUP_HI 7
`define TC_SETUP_LO 6
`define TC_WIDTH_HI 5
`define TC_WIDTH_LO 2
`define TC_HOLD_HI 1
`define TC_HOLD_LO 0
`define CF_MUX_BIT 4
`define CF_MAP_HI 3
`define CF_MAP_LO 2
`define CF_ALE_HI 1
`define CF_ALE_LO 0

`define MAP_INTERNAL 2'b00
`define MAP_SPLIT 2'b01
`define MAP_SPLIT_BANK 2'b10
`define MAP_EXTERNAL 2'b11

`define ONCHIP_LIMIT 16'h1000
`define FIXED_OVERHEAD 4

`endif

// File: tb/ext_mem_interface_timing_tb.sv
// Directed bench for the external memory sequencer
module ext_mem_interface_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic req = 0, req_write = 0, req_wide = 0;
    logic [7:0] paddr = 0, req_wdata = 0, bank = 0;
    logic [15:0] req_addr = 0;
    logic [31:0] pwdata = 0;
    logic [8:0] hi_seen = 0;
    wire [31:0] prdata;
    wire [7:0] rdata, addr_hi_out, addr_lo_out, ad_out, ad_in;
    wire pready, pslverr, req_ready, done, on_chip, addr_hi_oe, addr_lo_oe, ad_oe, ale, rd_n, wr_n;
    int fail_count = 0, num_checks = 0, sw, alh, n, m, tset, twid, thold, tale, nonmux, map;
    ext_mem_interface_timing DUT (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req(req), .req_write(req_write), .req_wide(req_wide), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .on_chip(on_chip),
        .rdata(rdata), .addr_hi_out(addr_hi_out), .addr_hi_oe(addr_hi_oe),
        .addr_lo_out(addr_lo_out), .addr_lo_oe(addr_lo_oe), .ad_out(ad_out),
        .ad_oe(ad_oe), .ad_in(ad_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n)
    );
    ext_sram_model u_sram (
        .clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .addr_hi_oe(addr_hi_oe),
        .addr_lo_oe(addr_lo_oe), .ad_oe(ad_oe), .addr_hi_out(addr_hi_out),
        .addr_lo_out(addr_lo_out), .ad_out(ad_out), .ad_in(ad_in)
    );
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (!rd_n || !wr_n)
        begin
            sw <= sw + 1;
            hi_seen <= {addr_hi_oe, addr_hi_out};
        end
        if (ale)
            alh <= alh + 1;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
        input logic err);
        int k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            fail_count++;
            stop_test;
        end
        if (!w)
            chk("prdata", x, prdata);
        chk("pslverr", err, pslverr);
        psel <= 0;
        penable <= 0;
    endtask
    task cpu(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d);
        logic [15:0] eff;
        logic off, hi;
        int cyc;
        eff = wide ? a : {bank, a[7:0]};
        off = map == 3 || (map != 0 && eff >= 16'h1000);
        hi = wide || map == 2;
        // Done lands in cycle N-1 of an N-cycle access
        cyc = off ? 3 + (nonmux ? 0 : 2 * (tale + 1)) + tset + twid + 1 + thold : 1;
        @(posedge clk);
        req <= 1;
        req_write <= w;
        req_wide <= wide;
        req_addr <= a;
        req_wdata <= d;
        sw = 0;
        alh = 0;
        @(posedge clk);
        req <= 0;
        for (n = 1; n < 40; n++)
        begin
            #1;
            if (done === 1'b1)
                break;
            @(posedge clk);
        end
        if (n == 40)
        begin
            fail_count++;
            stop_test;
        end
        chk("cycles", cyc, n);
        chk("on_chip", !off, on_chip);
        if (off)
        begin
            chk("strobe", twid + 1, sw);
            chk("ale high", nonmux ? 0 : tale + 1, alh);
            chk("upper", hi ? {1'b1, eff[15:8]} : 9'h0, hi ? hi_seen : {hi_seen[8], 8'h0});
            if (!w)
                chk("rdata", d, rdata);
        end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        apb(0, 8'h00, 0, 32'hff, 0);
        apb(0, 8'h10, 0, 0, 1);
        for (m = 1; m < 8; m++)
        begin
            if (m == 4)
                continue;
            nonmux = m / 4;
            map = m % 4;
            tset = m % 4;
            twid = (m * 5 + 1) % 16;
            thold = 3 - m % 4;
            tale = (m + 1) % 4;
            bank = 8'h30;
            apb(1, 8'h00, tset * 64 + twid * 4 + thold, 0, 0);
            apb(1, 8'h04, m * 4 + tale, 0, 0);
            apb(1, 8'h08, bank, 0, 0);
            apb(0, 8'h08, 0, bank, 0);
            apb(0, 8'h04, 0, m * 4 + tale, 0);
            cpu(1, 1, 16'(16'h4321 + m), 8'(8'ha0 + m));
            cpu(1, 0, 16'(m), 8'(8'h50 + m));
            cpu(0, 1, 16'(16'h4321 + m), 8'(8'ha0 + m));
            cpu(0, 0, 16'(m), 8'(8'h50 + m));
            apb(0, 8'h0c, 0, (8'h50 + m) << 8, 0);
            $display("Test mode %0d done", m);
        end
        map = 0;
        apb(1, 8'h04, 0, 0, 0);
        cpu(1, 1, 16'h4000, 8'h11);
        $display("Test internal map done");
        stop_test;
    end
endmodule // ext_mem_interface_timing_tb

// File: tb/ext_mem_timing_properties.sv
// Concurrent checks on the external memory pins and the request handshake
module ext_mem_timing_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ad_oe,
    input wire logic addr_lo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Low phase of 1 to 4 cycles plus setup of 0 to 3 before a strobe
    sequence ale_low_phase;
        (rd_n && wr_n) ##[1:7] !(rd_n && wr_n);
    endsequence
    sequence strobe_over;
        ##[1:16] (rd_n && wr_n);
    endsequence
    a_ale_high_width: assert property ($rose(ale) |-> ##[1:4] !ale)
        else $error("latch enable high too long");
    a_ale_low_width: assert property ($fell(ale) |-> ale_low_phase)
        else $error("latch enable low phase wrong");
    a_strobe_width: assert property ($fell(rd_n) || $fell(wr_n) |-> strobe_over)
        else $error("strobe too wide");
    a_data_setup: assert property ($fell(wr_n) |-> ad_oe && $past(ad_oe))
        else $error("write data late");
    a_data_hold: assert property ($rose(wr_n) |-> ##[0:3] !ad_oe)
        else $error("write data hold wrong");
    a_latch_drive: assert property (ale |-> ad_oe && !addr_lo_oe && rd_n && wr_n)
        else $error("shared pins wrong while latching");
    a_nonmux_pins: assert property (addr_lo_oe |-> !ale)
        else $error("latch enable in separate pin mode");
    a_access_bound: assert property (req && req_ready |-> ##[1:33] done)
        else $error("access did not finish");
endmodule // ext_mem_timing_checker

bind ext_mem_interface_timing ext_mem_timing_checker u_checker (
    .clk(clk), .reset_n(reset_n), .req(req), .req_ready(req_ready), .done(done),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_oe(ad_oe), .addr_lo_oe(addr_lo_oe)
);

// File: tb/ext_sram_model.sv
// Behavioural external SRAM with a clocked address latch
module ext_sram_model (
    input wire logic clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic addr_hi_oe,
    input wire logic addr_lo_oe,
    input wire logic ad_oe,
    input wire logic [7:0] addr_hi_out,
    input wire logic [7:0] addr_lo_out,
    input wire logic [7:0] ad_out,
    output logic [7:0] ad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    // Undriven upper lines stand for port latches left at zero
    wire [15:0] addr = {addr_hi_oe ? addr_hi_out : 8'h00, addr_lo_oe ? addr_lo_out : lat};
    // Sampled on the clock so the falling latch enable and the new pin value cannot race
    always @(posedge clk)
    begin
        if (ale)
            lat <= ad_out;
    end
    always @(posedge clk)
    begin
        if (!wr_n && ad_oe)
            mem[addr] <= ad_out;
    end
    always @(posedge clk)
    begin
        if (!rd_n)
            last <= mem[addr];
    end
    // Released pins show the inverse of the last byte so stale data cannot match
    assign ad_in = rd_n ? ~last : mem[addr];
endmodule // ext_sram_model

// File: verilog/ext_mem_interface_timing.v
// External memory interface timing sequencer with APB register slave
//
// The implementer's own choices: the register addresses and register access over APB.
`include "ext_mem_map.vh"

module ext_mem_interface_timing #(
    parameter ADDR_W = 16
)(
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire req,
    input wire req_write,
    input wire req_wide,
    input wire [ADDR_W-1:0] req_addr,
    input wire [7:0] req_wdata,
    output wire req_ready,
    output reg done,
    output reg on_chip,
    output reg [7:0] rdata,
    output reg [7:0] addr_hi_out,
    output reg addr_hi_oe,
    output reg [7:0] addr_lo_out,
    output reg addr_lo_oe,
    output reg [7:0] ad_out,
    output reg ad_oe,
    input wire [7:0] ad_in,
    output reg ale,
    output reg rd_n,
    output reg wr_n
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_ALE_H = 3'd2;
    localparam [2:0] ST_ALE_L = 3'd3;
    localparam [2:0] ST_SETUP = 3'd4;
    localparam [2:0] ST_STROBE = 3'd5;
    localparam [2:0] ST_HOLD = 3'd6;
    localparam [2:0] ST_FINISH = 3'd7;

    reg [7:0] ext_mem_timing_control;
    reg [7:0] ext_mem_config;
    reg [7:0] bank_select_reg;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] cnt;
    reg [3:0] next_cnt;
    reg acc_write;
    reg acc_mux;
    reg acc_hi_drive;
    reg [15:0] acc_addr;
    reg [7:0] acc_wdata;

    wire [1:0] addr_setup_sel = ext_mem_timing_control[`TC_SETUP_HI:`TC_SETUP_LO];
    wire [3:0] strobe_width_sel = ext_mem_timing_control[`TC_WIDTH_HI:`TC_WIDTH_LO];
    wire [1:0] addr_hold_sel = ext_mem_timing_control[`TC_HOLD_HI:`TC_HOLD_LO];
    wire mux_select_bit = ext_mem_config[`CF_MUX_BIT];
    wire [1:0] map_sel = ext_mem_config[`CF_MAP_HI:`CF_MAP_LO];
    wire [1:0] ale_sel = ext_mem_config[`CF_ALE_HI:`CF_ALE_LO];

    // Effective address: narrow pointers take the high byte from the bank register
    wire [15:0] eff_addr = req_wide ? req_addr[15:0] : {bank_select_reg, req_addr[7:0]};
    wire below_limit = eff_addr < `ONCHIP_LIMIT;
    wire goes_off = (map_sel == `MAP_EXTERNAL) ||
        (((map_sel == `MAP_SPLIT) || (map_sel == `MAP_SPLIT_BANK)) && !below_limit);
    // Narrow pointers drive the upper byte only in the banked split map
    wire hi_drive = req_wide || (map_sel == `MAP_SPLIT_BANK);

    wire bus_idle = (state == ST_IDLE);
    assign req_ready = bus_idle;
    wire take = req && bus_idle;

    // APB: zero wait states, errors on unmapped offsets
    wire apb_acc = psel && penable;
    wire hit_timing = paddr == `OFS_TIMING;
    wire hit_config = paddr == `OFS_CONFIG;
    wire hit_bank = paddr == `OFS_BANK;
    wire hit_status = paddr == `OFS_STATUS;
    wire mapped = hit_timing || hit_config || hit_bank || hit_status;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !mapped;
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        if (hit_timing)
            rd_mux = {24'h000000, ext_mem_timing_control};
        else if (hit_config)
            rd_mux = {24'h000000, 3'b000, ext_mem_config[4:0]};
        else if (hit_bank)
            rd_mux = {24'h000000, bank_select_reg};
        else if (hit_status)
            rd_mux = {16'h0000, rdata, 4'h0, state, ~bus_idle};
    end
    assign prdata = rd_mux;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_mem_timing_control <= `RST_TIMING;
            ext_mem_config <= `RST_CONFIG;
            bank_select_reg <= `RST_BANK;
        end
        else if (apb_acc && pwrite)
        begin
            // Timing changes mid-access only affect phases not yet entered
            if (hit_timing)
                ext_mem_timing_control <= pwdata[7:0];
            if (hit_config)
                ext_mem_config <= {3'b000, pwdata[4:0]};
            if (hit_bank)
                bank_select_reg <= pwdata[7:0];
        end
    end

    // Phase sequencer; IDLE and START plus FINISH and the ack make the fixed overhead
    always @*
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE:
            begin
                if (take && goes_off)
                    next_state = ST_START;
            end
            ST_START:
            begin
                if (acc_mux)
                begin
                    next_state = ST_ALE_H;
                    next_cnt = {2'b00, ale_sel};
                end
                else if (addr_setup_sel != 2'b00)
                begin
                    next_state = ST_SETUP;
                    next_cnt = {2'b00, addr_setup_sel} - 4'd1;
                end
                else
                begin
                    next_state = ST_STROBE;
                    next_cnt = strobe_width_sel;
                end
            end
            ST_ALE_H:
            begin
                if (cnt == 4'd0)
                begin
                    next_state = ST_ALE_L;
                    next_cnt = {2'b00, ale_sel};
                end
                else
                    next_cnt = cnt - 4'd1;
            end
            ST_ALE_L:
            begin
                if (cnt != 4'd0)
                    next_cnt = cnt - 4'd1;
                else if (addr_setup_sel != 2'b00)
                begin
                    next_state = ST_SETUP;
                    next_cnt = {2'b00, addr_setup_sel} - 4'd1;
                end
                else
                begin
                    next_state = ST_STROBE;
                    next_cnt = strobe_width_sel;
                end
            end
            ST_SETUP:
            begin
                if (cnt == 4'd0)
                begin
                    next_state = ST_STROBE;
                    next_cnt = strobe_width_sel;
                end
                else
                    next_cnt = cnt - 4'd1;
            end
            ST_STROBE:
            begin
                if (cnt != 4'd0)
                    next_cnt = cnt - 4'd1;
                else if (addr_hold_sel != 2'b00)
                begin
                    next_state = ST_HOLD;
                    next_cnt = {2'b00, addr_hold_sel} - 4'd1;
                end
                else
                    next_state = ST_FINISH;
            end
            ST_HOLD:
            begin
                if (cnt == 4'd0)
                    next_state = ST_FINISH;
                else
                    next_cnt = cnt - 4'd1;
            end
            ST_FINISH:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // State and phase counter
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            cnt <= 4'd0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Access attributes are frozen at acceptance so register writes cannot disturb them
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_write <= 1'b0;
            acc_mux <= 1'b0;
            acc_hi_drive <= 1'b0;
            acc_addr <= 16'h0000;
            acc_wdata <= 8'h00;
        end
        else if (take)
        begin
            acc_write <= req_write;
            acc_mux <= !mux_select_bit;
            acc_hi_drive <= hi_drive;
            acc_addr <= eff_addr;
            acc_wdata <= req_wdata;
        end
    end

    // Completion pulse; the request cycle, START, FINISH and this cycle are the fixed overhead
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done <= 1'b0;
            on_chip <= 1'b0;
        end
        else
        begin
            // On-chip hits are answered next cycle; the internal XRAM serves them
            done <= (take && !goes_off) || (state == ST_FINISH);
            on_chip <= take && !goes_off;
        end
    end

    // Read data is taken in the last strobe cycle, while the memory still drives the pins
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= 8'h00;
        else if (state == ST_STROBE && cnt == 4'd0 && !acc_write)
            rdata <= ad_in;
    end

    // Pin values are registered from the next state so pins change on clean edges
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_hi_out <= 8'h00;
            addr_hi_oe <= 1'b0;
            addr_lo_out <= 8'h00;
            addr_lo_oe <= 1'b0;
        end
        else
        begin
            // Address stays on the pins from START through FINISH
            if (take)
            begin
                addr_hi_out <= eff_addr[15:8];
                addr_lo_out <= eff_addr[7:0];
            end
            else
            begin
                addr_hi_out <= acc_addr[15:8];
                addr_lo_out <= acc_addr[7:0];
            end
            addr_hi_oe <= (next_state != ST_IDLE) &&
                ((state == ST_IDLE) ? hi_drive : acc_hi_drive);
            addr_lo_oe <= (next_state != ST_IDLE) &&
                ((state == ST_IDLE) ? mux_select_bit : !acc_mux);
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end
        else
        begin
            ale <= (next_state == ST_ALE_H);
            rd_n <= !((next_state == ST_STROBE) && !acc_write);
            wr_n <= !((next_state == ST_STROBE) && acc_write);
        end
    end

    // START is only entered on acceptance, so it is served by the take branch below
    wire data_phase = (next_state == ST_ALE_L) || (next_state == ST_SETUP) ||
        (next_state == ST_STROBE) || (next_state == ST_HOLD);

    // Stale attributes of the previous access must never drive the pins of a new one
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
        end
        else if (next_state == ST_ALE_H)
        begin
            ad_out <= acc_addr[7:0];
            ad_oe <= 1'b1;
        end
        else if (take && goes_off && req_write && mux_select_bit)
        begin
            // Separate pins: data goes out together with the address
            ad_out <= req_wdata;
            ad_oe <= 1'b1;
        end
        else if (acc_write && data_phase)
        begin
            ad_out <= acc_wdata;
            ad_oe <= 1'b1;
        end
        else
        begin
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
        end
    end

endmodule // ext_mem_interface_timing
